// ### design/ddg_damp_lut.sv
`timescale 1ns/1ps
module ddg_damp_lut
    import ddg_pkg::*;
(
    input  wire logic [2:0] code,
    input  wire logic [1:0] bw_class,
    output logic      [7:0] factor_x10,
    output logic            code_valid
);

    // ****************************************************************
    // Damping factor selection
    // ****************************************************************
    // Undefined codes fall back to the reset factor so the loop stays sane
    always_comb begin
        code_valid = (code >= DCODE_A) && (code <= DCODE_E); // [RULE7]
        factor_x10 = FACT_5; // [RULE3]
        case (bw_class)
            BW_LE4: begin
                factor_x10 = FACT_5; // [RULE4]
            end
            BW_8: begin
                if (code == DCODE_A) begin
                    factor_x10 = FACT_2P5;
                end
            end
            BW_35, BW_70: begin
                case (code)
                    DCODE_A: factor_x10 = FACT_1P2; // [RULE5]
                    DCODE_B: factor_x10 = FACT_2P5; // [RULE5]
                    DCODE_C: factor_x10 = FACT_5; // [RULE5]
                    DCODE_D: factor_x10 = FACT_10; // [RULE5]
                    DCODE_E: factor_x10 = (bw_class == BW_70) ? FACT_20 : FACT_10; // [RULE5]
                    default: factor_x10 = FACT_5;
                endcase
            end
            default: begin
                factor_x10 = FACT_5;
            end
        endcase
    end

endmodule

// ### design/ddg_dpll_damping_gain_config.sv
// Behaviour
// [RULE1] Main damping register is read/write and also carries a low-reference detector gain.
// [RULE2] Bits 6:4 give low-reference analog gain, applied only when main gain bit 7 set.
// [RULE3] Three-bit damping code picks a bandwidth-dependent factor; code 011 (factor 5) at reset.
// [RULE4] At 4 Hz bandwidth or lower every valid code gives damping factor 5.
// [RULE5] At 70 Hz codes 001 to 101 give factors 1.2, 2.5, 5, 10, 20.
// [RULE6] Aux gain register read/write, reset C2: bit 7 enable, 6:4 analog, 2:0 digital.
// [RULE7] Software avoids codes 000, 110, 111 and unused bits 7 and 3.
`timescale 1ns/1ps
module ddg_dpll_damping_gain_config
    import ddg_pkg::*;
#(
    parameter int ADDR_W = 10
)(
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [ADDR_W-1:0] haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [DATA_W-1:0] hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic      [DATA_W-1:0] hrdata,
    input  wire logic [1:0]        main_loop_bw_class,
    output logic      [2:0]        main_loop_damping_code,
    output logic      [7:0]        main_damping_factor_x10,
    output logic                   main_damping_code_valid,
    output logic      [2:0]        main_low_ref_analog_gain,
    output logic                   main_pd2_auto_gain_en,
    output logic      [2:0]        main_analog_fb_gain,
    output logic      [2:0]        main_digital_fb_gain,
    output logic                   aux_auto_gain_select_en,
    output logic      [2:0]        aux_analog_fb_gain,
    output logic      [2:0]        aux_digital_fb_gain
);

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    if (ADDR_W < ADDR_MIN_W) begin : g_addr_check
        $error("ADDR_W too small for the register map");
    end

    // ****************************************************************
    // Address decode
    // ****************************************************************
    function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [9:0] target);
        hit = (addr == ADDR_W'(target));
    endfunction

    logic                  ap_take;
    logic                  wr_pend_ff;
    logic                  nxt_wr_pend;
    logic [ADDR_W-1:0]     wr_addr_ff;
    logic [ADDR_W-1:0]     nxt_wr_addr;
    logic [REG_W-1:0]      damp_reg_ff;
    logic [REG_W-1:0]      nxt_damp_reg;
    logic [REG_W-1:0]      aux_reg_ff;
    logic [REG_W-1:0]      nxt_aux_reg;
    logic [REG_W-1:0]      mgain_reg_ff;
    logic [REG_W-1:0]      nxt_mgain_reg;
    logic [DATA_W-1:0]     hrdata_ff;
    logic [DATA_W-1:0]     nxt_hrdata;
    logic                  hreadyout_ff;
    logic                  hresp_ff;

    // Only the transfer type decides; sizes below a word still land in lane 0
    assign ap_take = hsel && hready && htrans[1];

    // ****************************************************************
    // Register file
    // ****************************************************************
    always_comb begin
        nxt_wr_pend   = ap_take && hwrite;
        nxt_wr_addr   = ap_take ? haddr : wr_addr_ff;
        nxt_damp_reg  = damp_reg_ff;
        nxt_aux_reg   = aux_reg_ff;
        nxt_mgain_reg = mgain_reg_ff;
        if (wr_pend_ff) begin
            if (hit(wr_addr_ff, ADDR_MAIN_DAMP)) begin
                nxt_damp_reg = hwdata[REG_W-1:0] & WMASK_DAMP; // [RULE1] [RULE7]
            end
            if (hit(wr_addr_ff, ADDR_AUX_GAIN)) begin
                nxt_aux_reg = hwdata[REG_W-1:0] & WMASK_GAIN; // [RULE6]
            end
            if (hit(wr_addr_ff, ADDR_MAIN_GAIN)) begin
                nxt_mgain_reg = hwdata[REG_W-1:0] & WMASK_GAIN;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff   <= 1'h0;
            wr_addr_ff   <= '0;
            damp_reg_ff  <= RST_MAIN_DAMP; // [RULE3]
            aux_reg_ff   <= RST_AUX_GAIN; // [RULE6]
            mgain_reg_ff <= RST_MAIN_GAIN;
        end else begin
            wr_pend_ff   <= nxt_wr_pend;
            wr_addr_ff   <= nxt_wr_addr;
            damp_reg_ff  <= nxt_damp_reg;
            aux_reg_ff   <= nxt_aux_reg;
            mgain_reg_ff <= nxt_mgain_reg;
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    // Reads see the next register values, so a read right behind a write
    // returns the freshly written data without a wait state
    always_comb begin
        nxt_hrdata = '0;
        if (ap_take && !hwrite) begin
            if (hit(haddr, ADDR_MAIN_DAMP)) begin
                nxt_hrdata = DATA_W'(nxt_damp_reg); // [RULE1]
            end else if (hit(haddr, ADDR_AUX_GAIN)) begin
                nxt_hrdata = DATA_W'(nxt_aux_reg); // [RULE6]
            end else if (hit(haddr, ADDR_MAIN_GAIN)) begin
                nxt_hrdata = DATA_W'(nxt_mgain_reg);
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_ff    <= '0;
            hreadyout_ff <= 1'h1;
            hresp_ff     <= HRESP_OKAY;
        end else begin
            hrdata_ff    <= nxt_hrdata;
            hreadyout_ff <= 1'h1;
            // Never varies, but kept in a flop so no output is driven by logic
            hresp_ff     <= HRESP_OKAY;
        end
    end

    assign hrdata    = hrdata_ff;
    assign hreadyout = hreadyout_ff;
    assign hresp     = hresp_ff;

    // ****************************************************************
    // Loop filter and detector configuration
    // ****************************************************************
    logic [7:0] lut_factor;
    logic       lut_valid;
    logic [7:0] fact_ff;
    logic [7:0] nxt_fact;
    logic       cvalid_ff;
    logic       nxt_cvalid;
    logic [2:0] lowg_ff;
    logic [2:0] nxt_lowg;

    ddg_damp_lut u_damp_lut (
        .code       (damp_reg_ff[CODE_MSB:CODE_LSB]),
        .bw_class   (main_loop_bw_class),
        .factor_x10 (lut_factor),
        .code_valid (lut_valid)
    );

    // Gain is forced to zero when auto selection is off, so the datapath
    // never picks up a stale low-reference setting
    always_comb begin
        nxt_fact   = lut_factor; // [RULE3] [RULE4] [RULE5]
        nxt_cvalid = lut_valid; // [RULE7]
        nxt_lowg   = mgain_reg_ff[GEN_BIT] ? damp_reg_ff[LOWG_MSB:LOWG_LSB] : 3'h0; // [RULE2]
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fact_ff   <= FACT_5;
            cvalid_ff <= 1'h1;
            lowg_ff   <= 3'h0;
        end else begin
            fact_ff   <= nxt_fact;
            cvalid_ff <= nxt_cvalid;
            lowg_ff   <= nxt_lowg;
        end
    end

    assign main_loop_damping_code   = damp_reg_ff[CODE_MSB:CODE_LSB];
    assign main_damping_factor_x10  = fact_ff;
    assign main_damping_code_valid  = cvalid_ff;
    assign main_low_ref_analog_gain = lowg_ff;
    assign main_pd2_auto_gain_en    = mgain_reg_ff[GEN_BIT];
    assign main_analog_fb_gain      = mgain_reg_ff[ANAG_MSB:ANAG_LSB];
    assign main_digital_fb_gain     = mgain_reg_ff[DIGG_MSB:DIGG_LSB];
    assign aux_auto_gain_select_en  = aux_reg_ff[GEN_BIT]; // [RULE6]
    assign aux_analog_fb_gain       = aux_reg_ff[ANAG_MSB:ANAG_LSB]; // [RULE6]
    assign aux_digital_fb_gain      = aux_reg_ff[DIGG_MSB:DIGG_LSB]; // [RULE6]

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_damp_wr;
        hsel && hready && htrans[1] && hwrite && hit(haddr, ADDR_MAIN_DAMP);
    endsequence

    sequence s_damp_rd;
        hsel && hready && htrans[1] && !hwrite && hit(haddr, ADDR_MAIN_DAMP);
    endsequence

    sequence s_aux_wr;
        hsel && hready && htrans[1] && hwrite && hit(haddr, ADDR_AUX_GAIN);
    endsequence

    sequence s_aux_rd;
        hsel && hready && htrans[1] && !hwrite && hit(haddr, ADDR_AUX_GAIN);
    endsequence

    sequence s_mgain_rd;
        hsel && hready && htrans[1] && !hwrite && hit(haddr, ADDR_MAIN_GAIN);
    endsequence

    AST_DAMP_WRITE: assert property ( // [RULE1]
        s_damp_wr |=> ##1 (main_loop_damping_code == $past(hwdata[2:0]))
            ##1 (main_damping_code_valid == (($past(main_loop_damping_code) >= DCODE_A)
            && ($past(main_loop_damping_code) <= DCODE_E))))
        else $error("damping code did not follow a write");

    AST_DAMP_READBACK: assert property ( // [RULE1]
        s_damp_rd |=> (hrdata[2:0] == main_loop_damping_code) && (hrdata[7] == 1'h0)
            && (hrdata[3] == 1'h0) && (hrdata[DATA_W-1:8] == '0))
        else $error("damping register read back wrong");

    AST_LOWG_GATED: assert property ( // [RULE2]
        !$past(main_pd2_auto_gain_en) |-> (main_low_ref_analog_gain == 3'h0))
        else $error("low reference gain applied while auto selection off");

    AST_LOWG_FOLLOWS: assert property ( // [RULE2]
        s_damp_wr ##1 main_pd2_auto_gain_en [*2] |=>
            (main_low_ref_analog_gain == $past(hwdata[6:4], 2)))
        else $error("low reference gain did not follow the written field");

    AST_DAMP_RESET: assert property ( // [RULE3]
        disable iff (1'b0) !hresetn |=> (main_loop_damping_code == DCODE_C))
        else $error("damping code not 011 after reset");

    AST_LOW_BW_FIVE: assert property ( // [RULE4]
        $past(main_loop_bw_class == BW_LE4) && $past(main_loop_damping_code >= DCODE_A)
            && $past(main_loop_damping_code <= DCODE_E) |-> (main_damping_factor_x10 == FACT_5))
        else $error("factor not 5 at low bandwidth");

    AST_70HZ_LOW: assert property ( // [RULE5]
        $past(main_loop_bw_class == BW_70) && $past(main_loop_damping_code == DCODE_A)
            |-> (main_damping_factor_x10 == FACT_1P2))
        else $error("code 001 at 70 Hz not 1.2");

    AST_70HZ_HIGH: assert property ( // [RULE5]
        $past(main_loop_bw_class == BW_70) && $past(main_loop_damping_code == DCODE_E)
            |-> (main_damping_factor_x10 == FACT_20))
        else $error("code 101 at 70 Hz not 20");

    AST_70HZ_MID: assert property ( // [RULE5]
        $past(main_loop_bw_class == BW_70) && $past(main_loop_damping_code == DCODE_D)
            |-> (main_damping_factor_x10 == FACT_10))
        else $error("code 100 at 70 Hz not 10");

    AST_70HZ_TWO_FIVE: assert property ( // [RULE5]
        $past(main_loop_bw_class == BW_70) && $past(main_loop_damping_code == DCODE_B)
            |-> (main_damping_factor_x10 == FACT_2P5))
        else $error("code 010 at 70 Hz not 2.5");

    AST_70HZ_FIVE: assert property ( // [RULE5]
        $past(main_loop_bw_class == BW_70) && $past(main_loop_damping_code == DCODE_C)
            |-> (main_damping_factor_x10 == FACT_5))
        else $error("code 011 at 70 Hz not 5");

    AST_AUX_RESET: assert property ( // [RULE6]
        disable iff (1'b0) !hresetn |=> aux_auto_gain_select_en && (aux_analog_fb_gain == 3'h4)
            && (aux_digital_fb_gain == 3'h2))
        else $error("aux gain register not C2 after reset");

    AST_AUX_WRITE_READ: assert property ( // [RULE6]
        s_aux_wr ##1 s_aux_rd |=> (hrdata[7:0] == ($past(hwdata[7:0]) & WMASK_GAIN)))
        else $error("aux gain write not read back");

    AST_AUX_FIELDS: assert property ( // [RULE6]
        s_aux_rd |=> (hrdata[7] == aux_auto_gain_select_en) && (hrdata[3] == 1'h0)
            && (hrdata[6:4] == aux_analog_fb_gain) && (hrdata[2:0] == aux_digital_fb_gain))
        else $error("aux gain fields misplaced");

    AST_AUX_WRITE: assert property ( // [RULE6]
        s_aux_wr |=> ##1 ({aux_auto_gain_select_en, aux_analog_fb_gain, 1'h0,
            aux_digital_fb_gain} == ($past(hwdata[7:0]) & WMASK_GAIN)))
        else $error("aux gain fields did not follow a write");

    AST_MGAIN_FIELDS: assert property ( // [RULE2]
        s_mgain_rd |=> (hrdata[7] == main_pd2_auto_gain_en) && (hrdata[3] == 1'h0)
            && (hrdata[6:4] == main_analog_fb_gain) && (hrdata[2:0] == main_digital_fb_gain))
        else $error("main gain fields misplaced");

    AST_HRDATA_IDLE: assert property ( // [RULE1]
        !(hsel && hready && htrans[1] && !hwrite) |=> (hrdata == '0))
        else $error("read data bus not cleared outside a read");

    AST_BUS_READY: assert property (
        hreadyout && (hresp == HRESP_OKAY))
        else $error("slave inserted a wait or error");

endmodule

// ### design/ddg_pkg.sv
package ddg_pkg;

    // ****************************************************************
    // Bus and register geometry
    // ****************************************************************
    localparam int         DATA_W         = 32;
    localparam int         REG_W          = 8;
    localparam int         ADDR_MIN_W     = 10;
    localparam logic [1:0] HTRANS_NONSEQ  = 2'h2;
    localparam logic [1:0] HTRANS_IDLE    = 2'h0;
    localparam logic       HRESP_OKAY     = 1'h0;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_MAIN_DAMP  = 8'h6B;
    localparam logic [7:0] IDX_AUX_GAIN   = 8'h6C;
    localparam logic [7:0] IDX_MAIN_GAIN  = 8'h6D;
    localparam logic [9:0] ADDR_MAIN_DAMP = {IDX_MAIN_DAMP, 2'h0};
    localparam logic [9:0] ADDR_AUX_GAIN  = {IDX_AUX_GAIN, 2'h0};
    localparam logic [9:0] ADDR_MAIN_GAIN = {IDX_MAIN_GAIN, 2'h0};

    // ****************************************************************
    // Reset values, writable bits and field positions
    // ****************************************************************
    localparam logic [7:0] RST_MAIN_DAMP  = 8'h13;
    localparam logic [7:0] RST_AUX_GAIN   = 8'hC2;
    localparam logic [7:0] RST_MAIN_GAIN  = 8'hC2;
    localparam logic [7:0] WMASK_DAMP     = 8'h77;
    localparam logic [7:0] WMASK_GAIN     = 8'hF7;
    localparam int         CODE_LSB       = 0;
    localparam int         CODE_MSB       = 2;
    localparam int         LOWG_LSB       = 4;
    localparam int         LOWG_MSB       = 6;
    localparam int         GEN_BIT        = 7;
    localparam int         ANAG_LSB       = 4;
    localparam int         ANAG_MSB       = 6;
    localparam int         DIGG_LSB       = 0;
    localparam int         DIGG_MSB       = 2;

    // ****************************************************************
    // Damping codes, loop bandwidth classes, factors in tenths
    // ****************************************************************
    localparam logic [2:0] DCODE_A        = 3'h1;
    localparam logic [2:0] DCODE_B        = 3'h2;
    localparam logic [2:0] DCODE_C        = 3'h3;
    localparam logic [2:0] DCODE_D        = 3'h4;
    localparam logic [2:0] DCODE_E        = 3'h5;
    localparam logic [1:0] BW_LE4         = 2'h0;
    localparam logic [1:0] BW_8           = 2'h1;
    localparam logic [1:0] BW_35          = 2'h2;
    localparam logic [1:0] BW_70          = 2'h3;
    localparam logic [7:0] FACT_1P2       = 8'h0C;
    localparam logic [7:0] FACT_2P5       = 8'h19;
    localparam logic [7:0] FACT_5         = 8'h32;
    localparam logic [7:0] FACT_10        = 8'h64;
    localparam logic [7:0] FACT_20        = 8'hC8;

endpackage

// ### testbench/tb.sv
`timescale 1ns/1ps
module tb;
    import ddg_pkg::*;
    // ****************************************************************
    // Signals
    // ****************************************************************
    logic              hclk;
    logic              hresetn;
    logic              hsel;
    logic [9:0]        haddr;
    logic [1:0]        htrans;
    logic              hwrite;
    logic [2:0]        hsize;
    logic [DATA_W-1:0] hwdata;
    logic              hreadyout;
    logic              hresp;
    logic [DATA_W-1:0] hrdata;
    logic [1:0]        bw_class;
    logic [2:0]        dcode;
    logic [7:0]        factor;
    logic              code_valid;
    logic [2:0]        low_gain;
    logic              main_gen;
    logic [2:0]        main_ana;
    logic [2:0]        main_dig;
    logic              aux_gen;
    logic [2:0]        aux_ana;
    logic [2:0]        aux_dig;
    logic [31:0]       rd_val;
    int                fails;
    int                samples_checked;
    int                cycles;

    ddg_dpll_damping_gain_config #(.ADDR_W(10)) uut (
        .hclk                    (hclk),
        .hresetn                 (hresetn),
        .hsel                    (hsel),
        .haddr                   (haddr),
        .htrans                  (htrans),
        .hwrite                  (hwrite),
        .hsize                   (hsize),
        .hwdata                  (hwdata),
        .hready                  (hreadyout),
        .hreadyout               (hreadyout),
        .hresp                   (hresp),
        .hrdata                  (hrdata),
        .main_loop_bw_class      (bw_class),
        .main_loop_damping_code  (dcode),
        .main_damping_factor_x10 (factor),
        .main_damping_code_valid (code_valid),
        .main_low_ref_analog_gain(low_gain),
        .main_pd2_auto_gain_en   (main_gen),
        .main_analog_fb_gain     (main_ana),
        .main_digital_fb_gain    (main_dig),
        .aux_auto_gain_select_en (aux_gen),
        .aux_analog_fb_gain      (aux_ana),
        .aux_digital_fb_gain     (aux_dig)
    );

    // ****************************************************************
    // Clock, timeout and report
    // ****************************************************************
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Whole run needs well under 1000 cycles; a hung handshake ends here
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fails = fails + 1;
            close_out();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // ****************************************************************
    // Bus tasks: address phase held until hready, then data phase
    // ****************************************************************
    task automatic bus_xfer(input logic [9:0] addr, input logic wr, input logic [31:0] wdata,
                            output logic [31:0] rdata);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr  <= addr;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= HTRANS_IDLE;
        hwdata <= wdata;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rdata = hrdata;
    endtask

    task automatic wr(input logic [9:0] addr, input logic [31:0] data);
        logic [31:0] unused;
        bus_xfer(addr, 1'b1, data, unused);
    endtask

    task automatic rd_chk(input string what, input logic [9:0] addr, input logic [31:0] exp);
        bus_xfer(addr, 1'b0, 32'h0000_0000, rd_val);
        chk(what, exp, rd_val);
    endtask

    // Datapath outputs trail the register commit by up to one cycle
    task automatic settle();
        repeat (3) @(posedge hclk);
        @(negedge hclk);
    endtask

    function automatic logic [7:0] exp_factor(input logic [1:0] bw, input logic [2:0] c);
        case (c)
            3'h1: return (bw == BW_LE4) ? FACT_5 : (bw == BW_8) ? FACT_2P5 : FACT_1P2;
            3'h2: return (bw == BW_LE4 || bw == BW_8) ? FACT_5 : FACT_2P5;
            3'h4: return (bw == BW_35 || bw == BW_70) ? FACT_10 : FACT_5;
            3'h5: return (bw == BW_70) ? FACT_20 : (bw == BW_35) ? FACT_10 : FACT_5;
            default: return FACT_5;
        endcase
    endfunction

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic test_reset();
        settle();
        chk("code", 32'h3, dcode);
        chk("factor", FACT_5, factor);
        chk("valid", 32'h1, code_valid);
        chk("low_gain", 32'h1, low_gain);
        chk("aux_fields", 32'h0000_00C2, {aux_gen, aux_ana, 1'b0, aux_dig});
        rd_chk("damp_rst", ADDR_MAIN_DAMP, 32'h0000_0013);
        rd_chk("aux_rst", ADDR_AUX_GAIN, 32'h0000_00C2);
        rd_chk("main_gain_rst", ADDR_MAIN_GAIN, 32'h0000_00C2);
    endtask

    task automatic test_rw_masks();
        wr(ADDR_MAIN_DAMP, 32'h0000_0075);
        rd_chk("damp_mask", ADDR_MAIN_DAMP, 32'h0000_0075);
        settle();
        chk("code5", 32'h5, dcode);
        chk("low_gain7", 32'h7, low_gain);
        wr(ADDR_AUX_GAIN, 32'hFFFF_FFFF);
        rd_chk("aux_mask", ADDR_AUX_GAIN, 32'h0000_00F7);
        wr(ADDR_AUX_GAIN, 32'h0000_0035);
        rd_chk("aux_rw", ADDR_AUX_GAIN, 32'h0000_0035);
        settle();
        chk("aux_fields", 32'h035, {aux_gen, aux_ana, 1'b0, aux_dig});
    endtask

    task automatic test_damping_table();
        for (int b = 0; b < 4; b++) begin
            for (int c = 1; c < 6; c++) begin
                @(posedge hclk);
                bw_class <= b[1:0];
                wr(ADDR_MAIN_DAMP, {29'h0, c[2:0]});
                settle();
                chk("factor", exp_factor(b[1:0], c[2:0]), factor);
                chk("valid", 32'h1, code_valid);
            end
        end
    endtask

    task automatic test_low_gain_gate();
        wr(ADDR_MAIN_DAMP, 32'h0000_0063);
        wr(ADDR_MAIN_GAIN, 32'h0000_0042);
        rd_chk("main_gain_off", ADDR_MAIN_GAIN, 32'h0000_0042);
        settle();
        chk("low_gain_off", 32'h0, low_gain);
        chk("main_fields", 32'h042, {main_gen, main_ana, 1'b0, main_dig});
        wr(ADDR_MAIN_GAIN, 32'h0000_00C2);
        settle();
        chk("low_gain_on", 32'h6, low_gain);
    endtask

    task automatic test_unmapped();
        wr(10'h1B8, 32'hFFFF_FFFF);
        rd_chk("unmapped", 10'h1B8, 32'h0000_0000);
        rd_chk("damp_kept", ADDR_MAIN_DAMP, 32'h0000_0063);
        chk("hresp", HRESP_OKAY, hresp);
    endtask

    // Write then read of one register back to back: the read must see the new value
    task automatic test_b2b();
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr  <= ADDR_AUX_GAIN;
        hwrite <= 1'b1;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hwrite <= 1'b0;
        hwdata <= 32'h0000_00A5;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= HTRANS_IDLE;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        chk("aux_b2b", 32'h0000_00A5, hrdata);
    endtask

    // Second reset in mid-run must bring written registers back to their defaults
    task automatic test_mid_reset();
        wr(ADDR_MAIN_DAMP, 32'h0000_0025);
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        settle();
        chk("code_rst2", 32'h3, dcode);
        chk("factor_rst2", FACT_5, factor);
        chk("low_gain_rst2", 32'h1, low_gain);
        chk("aux_rst2", 32'h0000_00C2, {aux_gen, aux_ana, 1'b0, aux_dig});
        rd_chk("damp_rst2", ADDR_MAIN_DAMP, 32'h0000_0013);
    endtask

    initial begin
        fails           = 0;
        samples_checked = 0;
        cycles          = 0;
        hresetn         = 1'b0;
        hsel            = 1'b0;
        haddr           = 10'h000;
        htrans          = HTRANS_IDLE;
        hwrite          = 1'b0;
        hsize           = 3'h2;
        hwdata          = 32'h0000_0000;
        bw_class        = BW_70;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        test_reset();
        test_rw_masks();
        test_damping_table();
        test_low_gain_gate();
        test_unmapped();
        test_b2b();
        test_mid_reset();
        close_out();
    end
endmodule
